// *** design/dso_pkg.sv ***
package dso_pkg;
  // ----------------------------------------
  // Clock and timer base
  // ----------------------------------------
  localparam int CLK_NS   = 10;
  localparam int TICK_NS  = 1000000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam int TMR_W    = 8;

  // ----------------------------------------
  // Terminals and selection codes
  // ----------------------------------------
  localparam int N_TERM = 4;
  localparam int SEL_W  = 6;
  localparam int N_COND = 20;
  localparam int W16    = 16;
  localparam int PCT_W  = 7;
  localparam logic [SEL_W-1:0] CODE_NO_FUNC = 6'h1D;
  localparam logic [SEL_W-1:0] CODE_FIRST   = 6'h26;
  localparam logic [SEL_W-1:0] CODE_LAST    = 6'h39;
  localparam logic [SEL_W-1:0] CODE_READY   = 6'h29;
  localparam logic [SEL_W-1:0] CODE_RUN_CFM = 6'h2E;

  // Condition index = code - CODE_FIRST
  localparam int C_PROBE1  = 0;
  localparam int C_PROBE2  = 1;
  localparam int C_RAMP    = 2;
  localparam int C_READY   = 3;
  localparam int C_TRV_ON  = 4;
  localparam int C_TRV_DIR = 5;
  localparam int C_REGEN   = 6;
  localparam int C_RUN_CMD = 7;
  localparam int C_RUN_CFM = 8;
  localparam int C_SAFE    = 9;
  localparam int C_DEV     = 10;
  localparam int C_DEV_LOW = 11;
  localparam int C_REF_RLS = 12;
  localparam int C_REF_RL2 = 13;
  localparam int C_REG_RLS = 14;
  localparam int C_STALL   = 15;
  localparam int C_UV_FLT  = 16;
  localparam int C_ABOVE   = 17;
  localparam int C_UV_WARN = 18;
  localparam int C_ZERO    = 19;

  // ----------------------------------------
  // Register map (byte offsets)
  // ----------------------------------------
  localparam logic [5:0] OFS_SEL_END = 6'h10;
  localparam logic [5:0] OFS_CFG     = 6'h10;
  localparam logic [5:0] OFS_PROBE   = 6'h14;
  localparam logic [5:0] OFS_DEV     = 6'h18;
  localparam logic [5:0] OFS_SPD     = 6'h1C;
  localparam logic [5:0] OFS_TIME    = 6'h20;
  localparam logic [5:0] OFS_LIM     = 6'h24;
  localparam logic [5:0] OFS_STAT    = 6'h28;

  localparam int CFG_W       = 7;
  localparam int CFG_TRV_LSB = 0;
  localparam int CFG_TRV_ACT = 2;
  localparam int CFG_SAFE_SW = 3;
  localparam int CFG_BRAKE   = 4;
  localparam int CFG_CONTACT = 5;
  localparam int CFG_MSTEP   = 6;
  localparam logic [1:0] TRV_OFF = 2'h0;

  localparam int PRB_W = 4;
  localparam int PRB1_LSB = 0;
  localparam int PRB2_LSB = 4;
  localparam int DEV_LVL_LSB = 0;
  localparam int DEV_BND_LSB = 16;
  localparam int SPD_UP_LSB = 0;
  localparam int SPD_ZR_LSB = 16;
  localparam int T_DEV_LSB = 0;
  localparam int T_ZERO_LSB = 8;
  localparam int T_STALL_LSB = 16;
  localparam int LIM_STL_LSB = 0;
  localparam int LIM_UVF_LSB = 16;
  localparam int LIM_UVW_LSB = 24;

  localparam logic [CFG_W-1:0] CFG_RST = 7'h00;
  localparam logic [7:0] PROBE_RST = 8'h10;
  localparam logic [31:0] DEV_RST  = 32'h0040_0200;
  localparam logic [31:0] SPD_RST  = 32'h0020_1000;
  localparam logic [31:0] TIME_RST = 32'h000A_0A0A;
  localparam logic [31:0] LIM_RST  = 32'h5055_4000;

  localparam logic [7:0] FLUX_RLS_PCT = 8'h4B;
  localparam logic [23:0] PCT_FULL    = 24'h000064;
endpackage : dso_pkg

// *** design/dso_hold_timer.sv ***
`timescale 1ns/100ps
`default_nettype none
module dso_hold_timer
  import dso_pkg::*;
(
  // Clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst,
  // Condition and time base
  input  wire logic             i_tick,
  input  wire logic             i_cond,
  input  wire logic [TMR_W-1:0] i_limit,
  // Result
  output logic                  o_flag
);
  logic [TMR_W-1:0] cnt_ff;
  logic [TMR_W-1:0] nxt_cnt;
  logic             flag_ff;
  wire              done = (cnt_ff >= i_limit);

  // Any break of the condition restarts the wait
  assign nxt_cnt = !i_cond ? '0 :
                   (i_tick && !done) ? cnt_ff + 1'b1 : cnt_ff;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_ff  <= '0;
      flag_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      flag_ff <= i_cond && done;
    end
  end

  assign o_flag = flag_ff;
endmodule // dso_hold_timer
`default_nettype wire

// *** design/dso_output_select.sv ***
`timescale 1ns/100ps
`default_nettype none
module dso_output_select
  import dso_pkg::*;
#(
  parameter int P_TICK_CYC = TICK_CYC
) (
  // Clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst,
  // Avalon-MM slave
  input  wire logic [5:0]        i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [31:0]       i_avs_writedata,
  input  wire logic [3:0]        i_avs_byteenable,
  output logic      [31:0]       o_avs_readdata,
  output logic                   o_avs_waitrequest,
  // Drive state, same clock
  input  wire logic              i_init_done,
  input  wire logic              i_fault,
  input  wire logic              i_run_cmd,
  input  wire logic              i_contactor,
  input  wire logic              i_gates_firing,
  input  wire logic              i_contact_cfm,
  input  wire logic              i_ramp_serial,
  input  wire logic              i_ramp_internal,
  input  wire logic              i_trq_at_zero,
  input  wire logic              i_dir_up,
  input  wire logic              i_trq_limit,
  input  wire logic              i_regen,
  input  wire logic [7:0]        i_flux_pct,
  input  wire logic              i_dc_inject,
  input  wire logic              i_brake_lift,
  input  wire logic [W16-1:0]    i_speed_ref,
  input  wire logic [W16-1:0]    i_speed_fb,
  input  wire logic [W16-1:0]    i_motor_speed,
  input  wire logic [W16-1:0]    i_motor_cur,
  input  wire logic [W16-1:0]    i_bus_volt,
  input  wire logic [W16-1:0]    i_line_volt,
  input  wire logic [W16-1:0]    i_watch_vars,
  // Logic input pins, asynchronous
  input  wire logic              i_ramp_pin,
  input  wire logic              i_travel_en_pin,
  input  wire logic              i_safe_off_present,
  // Output terminals
  output logic      [N_TERM-1:0] o_term
);
  localparam int TCK_W = $clog2(P_TICK_CYC);

  // ----------------------------------------
  // Pin synchronisers and time base
  // ----------------------------------------
  logic [2:0]       sync1_ff;
  logic [2:0]       sync2_ff;
  logic [TCK_W-1:0] tick_cnt_ff;
  logic             tick_ff;
  wire              tick_wrap = (tick_cnt_ff == TCK_W'(P_TICK_CYC - 1));
  wire              ramp_pin  = sync2_ff[0];
  wire              trv_en    = sync2_ff[1];
  wire              safe_in   = sync2_ff[2];

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1_ff    <= '0;
      sync2_ff    <= '0;
      tick_cnt_ff <= '0;
      tick_ff     <= 1'b0;
    end else begin
      sync1_ff    <= {i_safe_off_present, i_travel_en_pin, i_ramp_pin};
      sync2_ff    <= sync1_ff;
      tick_cnt_ff <= tick_wrap ? '0 : tick_cnt_ff + 1'b1;
      tick_ff     <= tick_wrap;
    end
  end

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  logic [SEL_W-1:0] sel_ff [N_TERM];
  logic [CFG_W-1:0] cfg_ff;
  logic [7:0]       probe_ff;
  logic [31:0]      dev_ff;
  logic [31:0]      spd_ff;
  logic [31:0]      time_ff;
  logic [31:0]      lim_ff;
  logic             wait_ff;
  logic [31:0]      rdata_ff;
  logic [31:0]      rd_mux;
  logic [N_COND-1:0] cond;
  logic [N_TERM-1:0] term_ff;

  // One wait cycle, then the answer; write lands on the answer edge
  wire req     = i_avs_read | i_avs_write;
  wire take    = req & wait_ff;
  wire wr_en   = i_avs_write & ~wait_ff;
  wire hit_sel = (i_avs_address < OFS_SEL_END);
  wire [1:0] sel_idx = i_avs_address[3:2];
  wire [31:0] stat_word = {8'h00, term_ff, cond};

  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return res;
  endfunction

  wire [31:0] wsel   = be_merge({26'h0, sel_ff[sel_idx]}, i_avs_writedata, i_avs_byteenable);
  wire [31:0] wcfg   = be_merge({25'h0, cfg_ff}, i_avs_writedata, i_avs_byteenable);
  wire [31:0] wprobe = be_merge({24'h0, probe_ff}, i_avs_writedata, i_avs_byteenable);

  always_comb begin
    if (hit_sel) begin
      rd_mux = {26'h0, sel_ff[sel_idx]};
    end else if (i_avs_address == OFS_CFG) begin
      rd_mux = {25'h0, cfg_ff};
    end else if (i_avs_address == OFS_PROBE) begin
      rd_mux = {24'h0, probe_ff};
    end else if (i_avs_address == OFS_DEV) begin
      rd_mux = dev_ff;
    end else if (i_avs_address == OFS_SPD) begin
      rd_mux = spd_ff;
    end else if (i_avs_address == OFS_TIME) begin
      rd_mux = time_ff;
    end else if (i_avs_address == OFS_LIM) begin
      rd_mux = lim_ff;
    end else if (i_avs_address == OFS_STAT) begin
      rd_mux = stat_word;
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      wait_ff  <= 1'b1;
      rdata_ff <= '0;
    end else begin
      wait_ff  <= ~take;
      rdata_ff <= take ? rd_mux : rdata_ff;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_ff   <= CFG_RST;
      probe_ff <= PROBE_RST;
      dev_ff   <= DEV_RST;
      spd_ff   <= SPD_RST;
      time_ff  <= TIME_RST;
      lim_ff   <= LIM_RST;
    end else if (wr_en) begin
      if (i_avs_address == OFS_CFG) begin
        cfg_ff <= wcfg[CFG_W-1:0];
      end else if (i_avs_address == OFS_PROBE) begin
        probe_ff <= wprobe[7:0];
      end else if (i_avs_address == OFS_DEV) begin
        dev_ff <= be_merge(dev_ff, i_avs_writedata, i_avs_byteenable);
      end else if (i_avs_address == OFS_SPD) begin
        spd_ff <= be_merge(spd_ff, i_avs_writedata, i_avs_byteenable);
      end else if (i_avs_address == OFS_TIME) begin
        time_ff <= be_merge(time_ff, i_avs_writedata, i_avs_byteenable);
      end else if (i_avs_address == OFS_LIM) begin
        lim_ff <= be_merge(lim_ff, i_avs_writedata, i_avs_byteenable);
      end
    end
  end

  // ----------------------------------------
  // Ramp-down and travel advice state
  // ----------------------------------------
  typedef enum logic {RAMP_IDLE, RAMP_ACTIVE} dso_ramp_t;
  dso_ramp_t ramp_ff;
  dso_ramp_t nxt_ramp;
  logic      run_d_ff;
  logic      trv_on_ff;
  wire       ramp_start = ramp_pin | i_ramp_serial | i_ramp_internal;
  wire       trv_feat   = cfg_ff[CFG_TRV_ACT];
  wire       trv_mode   = (cfg_ff[CFG_TRV_LSB +: 2] != TRV_OFF);
  wire       run_rise   = i_run_cmd & ~run_d_ff;

  // A new start wins over the end of a previous ramp
  always_comb begin
    case (ramp_ff)
      RAMP_IDLE:   nxt_ramp = ramp_start ? RAMP_ACTIVE : RAMP_IDLE;
      RAMP_ACTIVE: nxt_ramp = (i_trq_at_zero && !ramp_start) ? RAMP_IDLE : RAMP_ACTIVE;
      default:     nxt_ramp = RAMP_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ramp_ff   <= RAMP_IDLE;
      run_d_ff  <= 1'b0;
      trv_on_ff <= 1'b0;
    end else begin
      ramp_ff   <= nxt_ramp;
      run_d_ff  <= i_run_cmd;
      trv_on_ff <= i_run_cmd && (trv_on_ff ||
                   (run_rise && trv_mode && trv_en && trv_feat));
    end
  end

  // ----------------------------------------
  // Comparators
  // ----------------------------------------
  wire signed [W16:0] dev = $signed({i_speed_ref[W16-1], i_speed_ref}) -
                            $signed({i_speed_fb[W16-1], i_speed_fb});
  wire [W16:0] dev_abs = dev[W16] ? 17'(-dev) : 17'(dev);
  wire [W16:0] spd_abs = i_motor_speed[W16-1] ?
                         17'(-$signed({1'b1, i_motor_speed})) : {1'b0, i_motor_speed};
  wire [W16-1:0] dev_lvl = dev_ff[DEV_LVL_LSB +: W16];
  wire [W16-1:0] dev_bnd = dev_ff[DEV_BND_LSB +: W16];
  wire [W16-1:0] up_thr  = spd_ff[SPD_UP_LSB +: W16];
  wire [W16-1:0] zr_thr  = spd_ff[SPD_ZR_LSB +: W16];
  wire [23:0] bus_x100 = 24'(i_bus_volt) * PCT_FULL;
  wire [23:0] uvf_ref  = 24'(i_line_volt) * 24'(lim_ff[LIM_UVF_LSB +: PCT_W]);
  wire [23:0] uvw_ref  = 24'(i_line_volt) * 24'(lim_ff[LIM_UVW_LSB +: PCT_W]);

  wire dev_high   = dev > $signed({1'b0, dev_lvl});
  wire dev_inband = dev_abs <= {1'b0, dev_bnd};
  wire stall_lvl  = i_motor_cur >= lim_ff[LIM_STL_LSB +: W16];
  wire below_zero = spd_abs < {1'b0, zr_thr};
  wire flux_ok    = i_flux_pct >= FLUX_RLS_PCT;
  wire init_ok    = i_init_done & ~i_fault;
  logic dev_low_flag, stall_flag, zero_flag;

  // Persistence checks share one timer design
  dso_hold_timer u_dev_low (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_tick    (tick_ff),
    .i_cond    (dev_inband),
    .i_limit   (time_ff[T_DEV_LSB +: TMR_W]),
    .o_flag    (dev_low_flag)
  );

  dso_hold_timer u_stall (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_tick    (tick_ff),
    .i_cond    (stall_lvl),
    .i_limit   (time_ff[T_STALL_LSB +: TMR_W]),
    .o_flag    (stall_flag)
  );

  dso_hold_timer u_zero (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_tick    (tick_ff),
    .i_cond    (below_zero),
    .i_limit   (time_ff[T_ZERO_LSB +: TMR_W]),
    .o_flag    (zero_flag)
  );

  // ----------------------------------------
  // Condition vector, index = code - 38
  // ----------------------------------------
  assign cond[C_PROBE1]  = i_watch_vars[probe_ff[PRB1_LSB +: PRB_W]];
  assign cond[C_PROBE2]  = i_watch_vars[probe_ff[PRB2_LSB +: PRB_W]];
  assign cond[C_RAMP]    = (ramp_ff == RAMP_ACTIVE);
  assign cond[C_READY]   = init_ok;
  assign cond[C_TRV_ON]  = trv_on_ff;
  assign cond[C_TRV_DIR] = trv_feat & i_dir_up;
  assign cond[C_REGEN]   = i_trq_limit & i_regen;
  assign cond[C_RUN_CMD] = i_run_cmd;
  assign cond[C_RUN_CFM] = init_ok & i_run_cmd & i_contactor & i_gates_firing;
  assign cond[C_SAFE]    = cfg_ff[CFG_SAFE_SW] & ~safe_in;
  assign cond[C_DEV]     = dev_high;
  assign cond[C_DEV_LOW] = dev_low_flag;
  assign cond[C_REF_RLS] = flux_ok & ~i_dc_inject;
  assign cond[C_REF_RL2] = init_ok & i_run_cmd & ~i_dc_inject & cfg_ff[CFG_MSTEP] &
                           (~cfg_ff[CFG_CONTACT] | i_contact_cfm);
  assign cond[C_REG_RLS] = flux_ok & (~cfg_ff[CFG_BRAKE] | i_brake_lift);
  assign cond[C_STALL]   = stall_flag;
  assign cond[C_UV_FLT]  = bus_x100 < uvf_ref;
  assign cond[C_ABOVE]   = spd_abs > {1'b0, up_thr};
  assign cond[C_UV_WARN] = bus_x100 < uvw_ref;
  assign cond[C_ZERO]    = zero_flag;

  // ----------------------------------------
  // Terminal selection
  // ----------------------------------------
  // Codes outside 38..57, no-function among them, read as false
  for (genvar t = 0; t < N_TERM; t++) begin : g_sel
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
        sel_ff[t] <= CODE_NO_FUNC;
      end else if (wr_en && hit_sel && sel_idx == 2'(t)) begin
        sel_ff[t] <= wsel[SEL_W-1:0];
      end
    end
  end

  for (genvar t = 0; t < N_TERM; t++) begin : g_term
    wire in_rng = (sel_ff[t] >= CODE_FIRST) && (sel_ff[t] <= CODE_LAST);
    wire [SEL_W-1:0] idx = sel_ff[t] - CODE_FIRST;
    wire nxt_term = in_rng & cond[5'(idx)];

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
        term_ff[t] <= 1'b0;
      end else begin
        term_ff[t] <= nxt_term;
      end
    end
  end

  assign o_term            = term_ff;
  assign o_avs_readdata    = rdata_ff;
  assign o_avs_waitrequest = wait_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  sequence s_bus_answer;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence

  bus_answer_a: assert property (req && o_avs_waitrequest |=> s_bus_answer)
    else $error("bus answer not one cycle");
  no_func_low_a: assert property (sel_ff[0] == CODE_NO_FUNC |=> !o_term[0])
    else $error("no-function terminal went high");
  probe_follow_a: assert property (sel_ff[0] == CODE_FIRST && $stable(sel_ff[0]) |=>
    o_term[0] == $past(i_watch_vars[probe_ff[PRB1_LSB +: PRB_W]]))
    else $error("probe terminal wrong");
  ramp_hold_a: assert property (ramp_start ##1 !i_trq_at_zero |-> cond[C_RAMP])
    else $error("ramp flag lost");
  ready_fault_a: assert property (sel_ff[1] == CODE_READY && i_fault |=> !o_term[1])
    else $error("ready with fault");
  travel_run_a: assert property (!i_run_cmd |=> !cond[C_TRV_ON])
    else $error("travel advice without run");
  run_cfm_a: assert property (sel_ff[2] == CODE_RUN_CFM && !i_contactor |=> !o_term[2])
    else $error("run confirm without contactor");
  reg_flux_a: assert property (i_flux_pct < FLUX_RLS_PCT |-> !cond[C_REG_RLS])
    else $error("regulator release below flux");
  safe_sw_a: assert property (!cfg_ff[CFG_SAFE_SW] |-> !cond[C_SAFE])
    else $error("safe-off without switch");
  zero_drop_a: assert property (!below_zero |=> !cond[C_ZERO])
    else $error("standstill held at speed");
endmodule // dso_output_select
`default_nettype wire

// *** tb/dso_ctrl_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module dso_ctrl_model
  import dso_pkg::*;
(
  // Clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst,
  // Terminals read from the drive
  input  wire logic [N_TERM-1:0] i_term,
  output logic      [N_TERM-1:0] o_seen
);
  logic [N_TERM-1:0] seen_ff;
  // Input stage registers terminals, like a controller scan
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      seen_ff <= '0;
    end else begin
      seen_ff <= i_term;
    end
  end
  assign o_seen = seen_ff;
endmodule // dso_ctrl_model
`default_nettype wire

// *** tb/drive_status_output_select_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module drive_status_output_select_tb_top;
  import dso_pkg::*;
  logic clk, rst, rd_s, wr_s, wreq, init, flt, run, cont, gate, rser, tz, tlim, regen;
  logic [5:0] addr;
  logic [31:0] wdat, rdat;
  logic [15:0] spd, vbus, line, sref, cur, watch;
  logic [7:0] flux;
  logic dir, brk, rpin, tpin, safe;
  logic [N_TERM-1:0] term, seen;
  int bad_count, check_count;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----------------------------------------
  // Design and controller model
  // ----------------------------------------
  dso_output_select #(.P_TICK_CYC(4)) u_dut (
    .i_sys_clk(clk), .i_rst(rst), .i_avs_address(addr), .i_avs_read(rd_s), .i_avs_write(wr_s),
    .i_avs_writedata(wdat), .i_avs_byteenable(4'hF), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
    .i_init_done(init), .i_fault(flt), .i_run_cmd(run), .i_contactor(cont), .i_gates_firing(gate),
    .i_contact_cfm(1'b0), .i_ramp_serial(rser), .i_ramp_internal(1'b0), .i_trq_at_zero(tz),
    .i_dir_up(dir), .i_trq_limit(tlim), .i_regen(regen), .i_flux_pct(flux), .i_dc_inject(1'b0),
    .i_brake_lift(brk), .i_speed_ref(sref), .i_speed_fb(16'h0000), .i_motor_speed(spd),
    .i_motor_cur(cur), .i_bus_volt(vbus), .i_line_volt(line), .i_watch_vars(watch),
    .i_ramp_pin(rpin), .i_travel_en_pin(tpin), .i_safe_off_present(safe), .o_term(term));
  dso_ctrl_model u_ctrl (.i_sys_clk(clk), .i_rst(rst), .i_term(term), .o_seen(seen));
  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr_s <= w;
    rd_s <= ~w;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    if (n >= 20) chk("waitrequest", {31'h0, wreq}, 32'h0);
    wr_s <= 1'b0;
    rd_s <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, rdat, e);
  endtask
  // Model adds one stage; four edges cover pipeline plus model
  task automatic tchk(input string nm, input int t, input logic e);
    repeat (4) @(posedge clk);
    chk(nm, {31'h0, seen[t]}, {31'h0, e});
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {rst, rd_s, wr_s, init, flt, run, cont, gate, rser, tz, tlim, regen} = 12'h800;
    addr = 6'h00;
    wdat = 32'h0;
    spd = 16'h1000;
    vbus = 16'h0000;
    {dir, brk, rpin, tpin, safe} = 5'h00;
    flux = 8'h00;
    {sref, cur, watch} = 48'h0;
    line = 16'h0000;
    bad_count = 0;
    check_count = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(6'h00, 32'h1D, "sel0");
    rd(OFS_PROBE, {24'h0, PROBE_RST}, "probe");
    rd(OFS_DEV, DEV_RST, "dev");
    rd(6'h2C, 32'h0, "unmapped");
    run <= 1'b1;
    tchk("no_func", 0, 1'b0);
    bus(1'b1, 6'h00, 32'h2D);
    tchk("run_req", 0, 1'b1);
    bus(1'b1, 6'h04, 32'h29);
    init <= 1'b1;
    tchk("ready", 1, 1'b1);
    flt <= 1'b1;
    tchk("ready_flt", 1, 1'b0);
    bus(1'b1, 6'h08, 32'h2E);
    {flt, cont, gate} <= 3'b011;
    tchk("run_cfm", 2, 1'b1);
    gate <= 1'b0;
    tchk("run_cfm_off", 2, 1'b0);
    bus(1'b1, 6'h0C, 32'h2C);
    {tlim, regen} <= 2'b11;
    tchk("regen", 3, 1'b1);
    regen <= 1'b0;
    tchk("motoring", 3, 1'b0);
    $display("state flag tests done");
    bus(1'b1, 6'h00, 32'h37);
    spd <= 16'h1001;
    tchk("above", 0, 1'b1);
    spd <= 16'h1000;
    tchk("at_thr", 0, 1'b0);
    bus(1'b1, 6'h04, 32'h36);
    {vbus, line} <= {16'd84, 16'd100};
    tchk("uv_low", 1, 1'b1);
    vbus <= 16'd85;
    tchk("uv_edge", 1, 1'b0);
    bus(1'b1, 6'h08, 32'h28);
    @(posedge clk) rser <= 1'b1;
    @(posedge clk) rser <= 1'b0;
    tchk("ramp", 2, 1'b1);
    tz <= 1'b1;
    tchk("ramp_done", 2, 1'b0);
    bus(1'b1, 6'h0C, 32'h39);
    spd <= 16'h0000;
    tchk("zero_early", 3, 1'b0);
    repeat (60) @(posedge clk);
    chk("zero", {31'h0, seen[3]}, 32'h1);
    $display("threshold tests done");
    bus(1'b1, 6'h04, 32'h38);
    tchk("uv_warn_off", 1, 1'b0);
    vbus <= 16'd79;
    tchk("uv_warn", 1, 1'b1);
    bus(1'b1, 6'h00, 32'h26);
    watch <= 16'h0001;
    tchk("probe1", 0, 1'b1);
    bus(1'b1, OFS_PROBE, 32'h23);
    watch <= 16'h0004;
    tchk("probe1_idx", 0, 1'b0);
    bus(1'b1, 6'h04, 32'h27);
    tchk("probe2", 1, 1'b1);
    bus(1'b1, 6'h08, 32'h2B);
    {dir, tpin, run} <= 3'b110;
    tchk("dir_off", 2, 1'b0);
    bus(1'b1, OFS_CFG, 32'h05);
    tchk("dir_up", 2, 1'b1);
    bus(1'b1, 6'h0C, 32'h2A);
    tchk("trv_idle", 3, 1'b0);
    run <= 1'b1;
    tchk("trv_on", 3, 1'b1);
    dir <= 1'b0;
    tchk("dir_down", 2, 1'b0);
    bus(1'b1, 6'h00, 32'h2F);
    tchk("safe_sw_off", 0, 1'b0);
    bus(1'b1, OFS_CFG, 32'h0D);
    tchk("safe_off", 0, 1'b1);
    safe <= 1'b1;
    repeat (2) @(posedge clk);
    tchk("safe_in", 0, 1'b0);
    bus(1'b1, 6'h08, 32'h28);
    {tz, rpin} <= 2'b01;
    repeat (2) @(posedge clk);
    rpin <= 1'b0;
    tchk("ramp_pin", 2, 1'b1);
    bus(1'b1, 6'h00, 32'h32);
    flux <= 8'd75;
    tchk("ref_rls", 0, 1'b1);
    bus(1'b1, 6'h04, 32'h34);
    bus(1'b1, OFS_CFG, 32'h50);
    tchk("reg_brake", 1, 1'b0);
    brk <= 1'b1;
    tchk("reg_rls", 1, 1'b1);
    bus(1'b1, 6'h08, 32'h33);
    tchk("ref_rls2", 2, 1'b1);
    bus(1'b1, OFS_CFG, 32'h10);
    tchk("ref_rls2_src", 2, 1'b0);
    flux <= 8'd74;
    tchk("ref_rls_low", 0, 1'b0);
    bus(1'b1, 6'h04, 32'h30);
    bus(1'b1, 6'h0C, 32'h31);
    bus(1'b1, 6'h00, 32'h35);
    sref <= 16'h0201;
    tchk("dev_high", 1, 1'b1);
    sref <= 16'h0200;
    tchk("dev_at_lvl", 1, 1'b0);
    {sref, cur} <= {16'h0040, 16'h4000};
    tchk("dev_low_early", 3, 1'b0);
    tchk("stall_early", 0, 1'b0);
    repeat (60) @(posedge clk);
    chk("dev_low", {31'h0, seen[3]}, 32'h1);
    chk("stall", {31'h0, seen[0]}, 32'h1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk("rst_term", {28'h0, term}, 32'h0);
    rst <= 1'b0;
    rd(6'h0C, 32'h1D, "sel3_rst");
    $display("config tests done");
    stop_test();
  end
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    stop_test();
  end
endmodule // drive_status_output_select_tb_top
`default_nettype wire
